// >>> shared/pmd_pkg.sv
package pmd_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_REGS = 5;
  localparam int NUM_UNITS = 31;
  localparam int SYNC_STAGES = 3;

  // printed offsets are register indices; byte address is index * 4
  localparam logic [9:0] IDX_DISABLE_0 = 10'h10C;
  localparam logic [9:0] IDX_DISABLE_1 = 10'h10D;
  localparam logic [9:0] IDX_DISABLE_2 = 10'h10E;
  localparam logic [9:0] IDX_DISABLE_3 = 10'h10F;
  localparam logic [9:0] IDX_DISABLE_4 = 10'h110;
  localparam logic [9:0] REG_IDX [NUM_REGS] = '{IDX_DISABLE_0,
    IDX_DISABLE_1, IDX_DISABLE_2, IDX_DISABLE_3, IDX_DISABLE_4};

  localparam logic [7:0] REG_RESET = 8'h00;
  // implemented bits per register; the rest read as zero
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'h0F, 8'hFF, 8'hFF,
    8'hFF, 8'h17};

  localparam int BIT_NVM = 0;
  localparam int BIT_CRC = 1;
  localparam int BIT_SCAN = 2;
  localparam int BIT_SYSCLK = 3;

  // quarter-rate instruction clock enable
  localparam logic [1:0] INSTR_LAST = 2'h3;
  // instruction cycles before a re-enabled unit is ready
  localparam logic [1:0] SETTLE_TICKS = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] unused;
    logic sysclk_network_off;
    logic scanner_off;
    logic crc_engine_off;
    logic nvm_access_off;
  } disable0_s;

  typedef struct packed {
    logic pwm_unit1_off;
    logic capcomp2_off;
    logic capcomp1_off;
    logic timer6_off;
    logic timer4_off;
    logic timer2_off;
    logic timer3_off;
    logic timer1_off;
  } disable1_s;

  typedef struct packed {
    logic logic_cell3_off;
    logic logic_cell2_off;
    logic logic_cell1_off;
    logic waveform_gen_off;
    logic num_osc_off;
    logic pwm_unit4_off;
    logic pwm_unit3_off;
    logic pwm_unit2_off;
  } disable2_s;

  typedef struct packed {
    logic comparator2_off;
    logic comparator1_off;
    logic voltage_ref_off;
    logic sync_serial2_off;
    logic sync_serial1_off;
    logic uart_two_off;
    logic uart_one_off;
    logic logic_cell4_off;
  } disable3_s;

  typedef struct packed {
    logic [2:0] unused_hi;
    logic zero_cross_off;
    logic unused_lo;
    logic dac_two_off;
    logic dac_one_off;
    logic adc_off;
  } disable4_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HAVE_AW = 2'b01,
    WR_HAVE_W = 2'b10,
    WR_RESP = 2'b11
  } wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

endpackage

// >>> rtl/pmd_unit_ctrl.sv
`timescale 1ns/1ps
module pmd_unit_ctrl
  import pmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_tick,
  input wire logic [NUM_UNITS-1:0] disable_bits,
  output logic [NUM_UNITS-1:0] hold_reset,
  output logic [NUM_UNITS-1:0] clk_en,
  output logic [NUM_UNITS-1:0] sfr_ready
);

  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++)
    begin : g_unit
      logic [1:0] settle_reg;

      // registered so that gating never glitches on a bus write
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          hold_reset[u] <= 1'b0;
          clk_en[u] <= 1'b1;
        end
        else
        begin
          hold_reset[u] <= disable_bits[u];
          clk_en[u] <= ~disable_bits[u];
        end
      end

      // a cleared unit leaves reset at its power-on values
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          settle_reg <= SETTLE_TICKS;
          sfr_ready[u] <= 1'b1;
        end
        else if (disable_bits[u])
        begin
          settle_reg <= 2'h0;
          sfr_ready[u] <= 1'b0;
        end
        else
        begin
          if (instr_tick && settle_reg != SETTLE_TICKS)
            settle_reg <= settle_reg + 2'h1;
          sfr_ready[u] <= (settle_reg == SETTLE_TICKS);
        end
      end

      a_gate_pair_match: assert property (
        @(posedge aclk) disable iff (!aresetn)
        hold_reset[u] != clk_en[u])
        else $error("hold and clock enable disagree");

      a_not_ready_held: assert property (
        @(posedge aclk) disable iff (!aresetn)
        hold_reset[u] |-> !sfr_ready[u])
        else $error("unit ready while held in reset");
    end
  endgenerate

endmodule

// >>> rtl/pmd_ctrl.sv
`timescale 1ns/1ps
// Function
// - scanner held off while bit 2 set
// - crc engine held off while bit 1 set
// - bit 0 blocks memory access, control writes
// - clock gate stops full rate only
// - second register maps pwm, capture, timers
// - third register maps cells, generator, pwm
// - fourth register maps comparators, serial, uart
// - fifth register four bits, rest zero
// - zero-cross disable depends on fuse
// - five consecutive registers from 0x010C
// - disabled unit held reset, outputs off
// - re-enabled unit starts at reset values
// - every reset clears all disable bits
module pmd_ctrl
  import pmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic zcd_fuse_always_on,
  input wire logic nvm_rd_req,
  input wire logic nvm_wr_req,
  input wire logic nvm_ctrl_wr_req,
  output logic nvm_rd_grant,
  output logic nvm_wr_grant,
  output logic nvm_ctrl_wr_grant,
  output logic sysclk_gate_en,
  output logic instr_clk_en,
  output logic [NUM_UNITS-1:0] unit_hold_reset,
  output logic [NUM_UNITS-1:0] unit_clk_en,
  output logic [NUM_UNITS-1:0] unit_sfr_ready
);

  wr_state_e wr_state_reg;
  wr_state_e wr_state_next;
  rd_state_e rd_state_reg;
  rd_state_e rd_state_next;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [3:0] wr_dec;
  logic [3:0] rd_dec;
  logic [7:0] reg_file [NUM_REGS];
  logic [2:0] fuse_sync_reg;
  logic fuse_reg;
  logic [1:0] div_reg;
  logic zero_cross_eff;
  logic [NUM_UNITS-1:0] unit_disable;
  disable0_s dis0;
  disable1_s dis1;
  disable2_s dis2;
  disable3_s dis3;
  disable4_s dis4;

  // bit 3 = hit, bits 2:0 = register number; low address bits ignored
  function automatic logic [3:0] find_reg(input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < NUM_REGS; k++)
    begin
      if (a[ADDR_W-1:2] == REG_IDX[k])
        r = {1'b1, 3'(k)};
    end
    return r;
  endfunction

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_addr = (wr_state_reg == WR_HAVE_AW) ? awaddr_reg : s_axi_awaddr;
  assign wr_data = (wr_state_reg == WR_HAVE_W) ? wdata_reg : s_axi_wdata;
  assign wr_strb = (wr_state_reg == WR_HAVE_W) ? wstrb_reg : s_axi_wstrb;
  assign wr_dec = find_reg(wr_addr);
  assign rd_dec = find_reg(s_axi_araddr);

  always_comb
  begin
    wr_state_next = wr_state_reg;
    wr_fire = 1'b0;
    case (wr_state_reg)
      WR_IDLE:
      begin
        if (aw_hs && w_hs)
        begin
          wr_state_next = WR_RESP;
          wr_fire = 1'b1;
        end
        else if (aw_hs)
          wr_state_next = WR_HAVE_AW;
        else if (w_hs)
          wr_state_next = WR_HAVE_W;
      end
      WR_HAVE_AW:
      begin
        if (w_hs)
        begin
          wr_state_next = WR_RESP;
          wr_fire = 1'b1;
        end
      end
      WR_HAVE_W:
      begin
        if (aw_hs)
        begin
          wr_state_next = WR_RESP;
          wr_fire = 1'b1;
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
          wr_state_next = WR_IDLE;
      end
      default: wr_state_next = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_reg <= WR_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      s_axi_awready <= (wr_state_next == WR_IDLE) ||
                       (wr_state_next == WR_HAVE_W);
      s_axi_wready <= (wr_state_next == WR_IDLE) ||
                      (wr_state_next == WR_HAVE_AW);
      s_axi_bvalid <= (wr_state_next == WR_RESP);
      if (wr_fire)
        s_axi_bresp <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (aw_hs)
        awaddr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // only byte lane 0 carries the 8-bit registers
  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++)
    begin : g_reg
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          reg_file[i] <= REG_RESET;
        else if (wr_fire && wr_dec[3] && wr_dec[2:0] == 3'(i) && wr_strb[0])
          reg_file[i] <= wr_data[7:0] & REG_MASK[i];
      end
    end
  endgenerate

  always_comb
  begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE:
      begin
        if (ar_hs)
          rd_state_next = RD_RESP;
      end
      RD_RESP:
      begin
        if (s_axi_rready)
          rd_state_next = RD_IDLE;
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_reg <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      s_axi_arready <= (rd_state_next == RD_IDLE);
      s_axi_rvalid <= (rd_state_next == RD_RESP);
      if (ar_hs)
      begin
        s_axi_rdata <= rd_dec[3] ? {24'h0, reg_file[rd_dec[2:0]]} : '0;
        s_axi_rresp <= rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // fuse is a pin level; accept only once two later stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fuse_sync_reg <= 3'h0;
      fuse_reg <= 1'b0;
    end
    else
    begin
      fuse_sync_reg <= {fuse_sync_reg[1:0], zcd_fuse_always_on};
      if (fuse_sync_reg[1] == fuse_sync_reg[2])
        fuse_reg <= fuse_sync_reg[2];
    end
  end

  // instruction clock keeps running whatever the gate bit says
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg <= 2'h0;
      instr_clk_en <= 1'b0;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      instr_clk_en <= (div_reg == INSTR_LAST);
    end
  end

  assign dis0 = disable0_s'(reg_file[0]);
  assign dis1 = disable1_s'(reg_file[1]);
  assign dis2 = disable2_s'(reg_file[2]);
  assign dis3 = disable3_s'(reg_file[3]);
  assign dis4 = disable4_s'(reg_file[4]);
  // a fuse forcing the detector on overrides the disable bit
  assign zero_cross_eff = dis4.zero_cross_off && !fuse_reg;

  assign unit_disable = {zero_cross_eff, dis4.dac_two_off,
    dis4.dac_one_off, dis4.adc_off,
    dis3, dis2, dis1,
    dis0.scanner_off, dis0.crc_engine_off,
    dis0.nvm_access_off};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sysclk_gate_en <= 1'b1;
      nvm_rd_grant <= 1'b0;
      nvm_wr_grant <= 1'b0;
      nvm_ctrl_wr_grant <= 1'b0;
    end
    else
    begin
      sysclk_gate_en <= !dis0.sysclk_network_off;
      nvm_rd_grant <= nvm_rd_req && !dis0.nvm_access_off;
      nvm_wr_grant <= nvm_wr_req && !dis0.nvm_access_off;
      nvm_ctrl_wr_grant <= nvm_ctrl_wr_req && !dis0.nvm_access_off;
    end
  end

  pmd_unit_ctrl u_units (
    .aclk(aclk),
    .aresetn(aresetn),
    .instr_tick(instr_clk_en),
    .disable_bits(unit_disable),
    .hold_reset(unit_hold_reset),
    .clk_en(unit_clk_en),
    .sfr_ready(unit_sfr_ready)
  );

  a_write_to_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_dec == 4'h9 && wr_strb[0])
    |=> ##1 unit_hold_reset[10:3] == $past(wr_data[7:0], 2))
    else $error("timer group hold not set two edges after write");
  a_scan_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    dis0.scanner_off |=> unit_hold_reset[2] && !unit_clk_en[2])
    else $error("scanner not held while disabled");
  a_crc_release: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !dis0.crc_engine_off |=> !unit_hold_reset[1])
    else $error("crc engine held while enabled");
  a_nvm_blocked: assert property (
    @(posedge aclk) disable iff (!aresetn)
    dis0.nvm_access_off |=> !nvm_rd_grant && !nvm_wr_grant &&
    !nvm_ctrl_wr_grant)
    else $error("memory access granted while blocked");
  a_nvm_allowed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!dis0.nvm_access_off && nvm_rd_req) |=> nvm_rd_grant)
    else $error("memory read refused while allowed");
  a_instr_period: assert property (
    @(posedge aclk) disable iff (!aresetn)
    instr_clk_en |=> !instr_clk_en [*3] ##1 instr_clk_en)
    else $error("instruction enable not every fourth cycle");
  a_sysclk_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(dis0.sysclk_network_off) |=> !sysclk_gate_en)
    else $error("system clock gate still open");
  a_unimpl_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (reg_file[4] & ~REG_MASK[4]) == 8'h00 &&
    (reg_file[0] & ~REG_MASK[0]) == 8'h00)
    else $error("unimplemented bit set");
  a_fuse_override: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (fuse_reg && $past(fuse_reg)) |-> !unit_hold_reset[NUM_UNITS-1])
    else $error("zero-cross held despite fuse");
  a_reset_clears: assert property (
    @(posedge aclk)
    !aresetn |=> reg_file[0] == REG_RESET && reg_file[1] == REG_RESET &&
    reg_file[2] == REG_RESET && reg_file[3] == REG_RESET &&
    reg_file[4] == REG_RESET)
    else $error("disable bits not cleared by reset");
  a_unmapped_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_hs && !rd_dec[3]) |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == '0)
    else $error("unmapped read not answered with error");
  a_bvalid_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  import pmd_pkg::*;
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic zcd_fuse_always_on, nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req;
  logic nvm_rd_grant, nvm_wr_grant, nvm_ctrl_wr_grant;
  logic sysclk_gate_en, instr_clk_en;
  logic [NUM_UNITS-1:0] unit_hold_reset, unit_clk_en, unit_sfr_ready;
  int miscompares;
  int n_compared;
  int pulses;
  logic fuse_v;
  logic [7:0] shadow [NUM_REGS];
  logic [33:0] rd_q [$];
  logic [1:0] wr_q [$];

  pmd_ctrl dut_u (.*);

  always #25 aclk = ~aclk;

  task automatic compare(string what, logic [33:0] exp, logic [33:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // each bus answer is matched to the oldest note left by its driver
  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      if (rd_q.size() == 0)
        compare("stray read", 34'h0, 34'h1);
      else
        compare("read", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
    begin
      if (wr_q.size() == 0)
        compare("stray bresp", 34'h0, 34'h1);
      else
        compare("bresp", 34'(wr_q.pop_front()), 34'(s_axi_bresp));
    end
  end

  function automatic logic [ADDR_W-1:0] addr_of(logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [NUM_UNITS-1:0] exp_hold(logic fuse);
    return {shadow[4][4] & ~fuse, shadow[4][2:0], shadow[3], shadow[2],
      shadow[1], shadow[0][2:0]};
  endfunction

  task automatic axi_write(logic [ADDR_W-1:0] a, logic [7:0] d,
    logic [3:0] strb, logic [1:0] exp);
    int n;
    @(posedge aclk);
    wr_q.push_back(exp);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(logic [ADDR_W-1:0] a, logic [33:0] exp);
    int n;
    @(posedge aclk);
    rd_q.push_back(exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr_reg(int i, logic [7:0] d);
    axi_write(addr_of(REG_IDX[i]), d, 4'hF, RESP_OKAY);
    shadow[i] = d & REG_MASK[i];
  endtask

  task automatic rd_reg(int i);
    axi_read(addr_of(REG_IDX[i]), {RESP_OKAY, 24'h0, shadow[i]});
  endtask

  // fuse passes a three-flop synchroniser, so allow it to settle
  task automatic check_units(logic fuse);
    repeat (5) @(posedge aclk);
    #1;
    compare("unit_hold_reset", 34'(exp_hold(fuse)), 34'(unit_hold_reset));
    compare("unit_clk_en", 34'(31'(~exp_hold(fuse))),
      34'(unit_clk_en));
    compare("sysclk_gate_en", 34'(!shadow[0][3]), 34'(sysclk_gate_en));
  endtask

  task automatic nvm_probe(logic [2:0] r);
    @(posedge aclk);
    {nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req} <= r;
    @(posedge aclk);
    #1;
    compare("nvm grants", 34'(r & {3{~shadow[0][0]}}),
      34'({nvm_rd_grant, nvm_wr_grant, nvm_ctrl_wr_grant}));
  endtask

  task automatic close_out();
    compare("pending answers", 34'h0, 34'(rd_q.size() + wr_q.size()));
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out();
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb, s_axi_wdata} = '0;
    {zcd_fuse_always_on, nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req} = '0;
    miscompares = 0;
    n_compared = 0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    void'($urandom(40916));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
    axi_read(addr_of(10'h10B), {RESP_SLVERR, 32'h0});
    axi_read(addr_of(10'h111), {RESP_SLVERR, 32'h0});
    axi_write(addr_of(10'h10B), 8'hFF, 4'hF, RESP_SLVERR);
    for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
    check_units(1'b0);
    $display("test reset_and_map done");
    for (int i = 0; i < NUM_REGS; i++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        wr_reg(i, 8'h01 << b);
        rd_reg(i);
        check_units(1'b0);
      end
      wr_reg(i, 8'h00);
    end
    $display("test walking_bits done");
    wr_reg(4, 8'h10);
    for (int f = 0; f < 2; f++)
    begin
      @(posedge aclk);
      zcd_fuse_always_on <= f[0];
      check_units(f[0]);
    end
    for (int k = 0; k < 20; k++)
    begin
      wr_reg(k % NUM_REGS, 8'($urandom));
      rd_reg(k % NUM_REGS);
      @(posedge aclk);
      fuse_v = 1'($urandom);
      zcd_fuse_always_on <= fuse_v;
      check_units(fuse_v);
    end
    $display("test random_values done");
    axi_write(addr_of(REG_IDX[1]), ~shadow[1], 4'h0, RESP_OKAY);
    rd_reg(1);
    for (int v = 0; v < 2; v++)
    begin
      wr_reg(0, 8'(v));
      for (int k = 0; k < 8; k++) nvm_probe(3'(k));
    end
    @(posedge aclk);
    {nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req} <= 3'h0;
    $display("test nvm_access done");
    // the instruction-rate enable must keep running with the gate shut
    wr_reg(0, 8'h08);
    check_units(zcd_fuse_always_on);
    pulses = 0;
    repeat (16) @(posedge aclk) pulses += (instr_clk_en === 1'b1);
    compare("instr pulses", 34'd4, 34'(pulses));
    $display("test clock_gate done");
    wr_reg(1, 8'h01);
    repeat (20) @(posedge aclk);
    #1;
    compare("sfr_ready off", 34'h0, 34'(unit_sfr_ready[3]));
    wr_reg(1, 8'h00);
    #1;
    compare("sfr_ready early", 34'h0, 34'(unit_sfr_ready[3]));
    repeat (16) @(posedge aclk);
    #1;
    compare("sfr_ready late", 34'h1, 34'(unit_sfr_ready[3]));
    $display("test reenable done");
    for (int i = 0; i < NUM_REGS; i++) wr_reg(i, 8'hFF);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
    check_units(zcd_fuse_always_on);
    $display("test second_reset done");
    repeat (4) @(posedge aclk);
    close_out();
  end
endmodule
